// file: core/charger_regs_defines.svh
`ifndef CHARGER_REGS_DEFINES_SVH
`define CHARGER_REGS_DEFINES_SVH

// ***************************************
// register identifiers
// ***************************************
`define ID_PRODUCT_IDENTITY 16'h0100
`define ID_SYNC_GROUP       16'h0104
`define ID_FEATURE_FLAGS    16'h0140
`define ID_ON_OFF           16'h0200
`define ID_CHARGE_PHASE     16'h0201
`define ID_REMOTE_MASK      16'h0202
`define ID_CAUSE_NARROW     16'h0205
`define ID_CAUSE_WIDE       16'h0207

// ***************************************
// field values and layouts
// ***************************************
`define IDENTITY_INSTANCE   8'h00
`define IDENTITY_RESERVED   8'hff
`define FEATURE_DEFINED     32'h0e3f_ffff
`define MODE_OFF_LEGACY     8'h00
`define MODE_OFF            8'h04
`define MODE_ON             8'h01
`define REMOTE_ONOFF_BIT    1
`define REMOTE_MASK_RESET   32'h0000_0002
`define SOFT_ON_RESET       1'b1
`define SYNC_GROUP_RESET    8'h00
`define CAUSE_DEFINED       32'h0000_027f
`define CAUSE_NO_INPUT      0
`define CAUSE_PHYS_SWITCH   1
`define CAUSE_SOFT_SWITCH   2
`define CAUSE_REMOTE_INPUT  3
`define CAUSE_INTERNAL      4
`define CAUSE_NO_CREDIT     5
`define CAUSE_BATT_MGMT     6
`define CAUSE_BATT_COLD     9

// ***************************************
// charge phase codes
// ***************************************
`define PHASE_NOT_CHARGING  8'h00
`define PHASE_FAULT         8'h02
`define PHASE_BULK          8'h03
`define PHASE_HOLD          8'h04
`define PHASE_MAINTAIN      8'h05
`define PHASE_STORAGE       8'h06
`define PHASE_MANUAL_EQ     8'h07
`define PHASE_WAKE_UP       8'hf5
`define PHASE_AUTO_EQ       8'hf7
`define PHASE_UPDATE        8'hfa
`define PHASE_EXTERNAL      8'hfc
`define PHASE_NO_INFO       8'hff

`endif

// file: core/charger_regs_pkg.sv
package charger_regs_pkg;

   // raw phase reported by the charging engine
   typedef enum logic [3:0] {
      eng_idle     = 4'h0,
      eng_fault    = 4'h1,
      eng_bulk     = 4'h2,
      eng_hold     = 4'h3,
      eng_maintain = 4'h4,
      eng_storage  = 4'h5,
      eng_wake_up  = 4'h6,
      eng_update   = 4'h7,
      eng_external = 4'h8,
      eng_unknown  = 4'h9
   } engine_phase_type;

   typedef enum logic [1:0] {
      st_idle   = 2'b01,
      st_answer = 2'b10
   } access_state_type;

endpackage

// file: core/charger_control_status_registers.sv
`timescale 1ns/10ps
`include "charger_regs_defines.svh"

module charger_control_status_registers (
   // clock and reset
   input  wire logic                              clock_i,
   input  wire logic                              nrst_i,
   // get/set access
   input  wire logic                              req_valid_i,
   input  wire logic                              req_write_i,
   input  wire logic [15:0]                       req_id_i,
   input  wire logic [31:0]                       req_wdata_i,
   output logic                                   req_ready_o,
   output logic                                   rsp_valid_o,
   output logic [31:0]                            rsp_data_o,
   output logic                                   rsp_error_o,
   // device restart
   input  wire logic                              restart_i,
   // static product data
   input  wire logic [15:0]                       product_code_i,
   input  wire logic [31:0]                       feature_present_i,
   // charging engine status
   input  wire charger_regs_pkg::engine_phase_type engine_phase_i,
   input  wire logic                              manual_eq_i,
   input  wire logic                              auto_eq_i,
   input  wire logic                              batt_protect_i,
   // shutdown causes
   input  wire logic                              no_input_power_i,
   input  wire logic                              physical_switch_off_i,
   input  wire logic                              remote_input_off_i,
   input  wire logic                              internal_off_i,
   input  wire logic                              credit_exhausted_i,
   input  wire logic                              battery_management_system_off_i,
   input  wire logic                              battery_cold_i,
   // control outputs
   output logic                                   charger_on_o,
   output logic [7:0]                             sync_group_number_o
);

   // ***************************************
   // storage
   // ***************************************
   charger_regs_pkg::access_state_type state;
   logic        soft_on;
   logic [31:0] remote_enable_mask;
   logic [7:0]  sync_group_number;
   logic [7:0]  charge_phase;
   logic [7:0]  next_charge_phase;
   logic [7:0]  shutdown_cause_narrow;
   logic [31:0] shutdown_cause_wide;
   logic [31:0] next_cause;
   logic [31:0] read_value;
   logic        id_known;
   logic        id_writable;
   logic        take;
   logic        set_access;
   logic        mode_write_ok;
   logic [7:0]  mode_value;

   assign req_ready_o   = (state == charger_regs_pkg::st_idle);
   assign rsp_valid_o   = (state == charger_regs_pkg::st_answer);
   assign take          = req_valid_i & req_ready_o;
   assign set_access    = take & req_write_i;
   assign mode_write_ok = set_access & (req_id_i == `ID_ON_OFF)
                          & remote_enable_mask[`REMOTE_ONOFF_BIT];
   assign mode_value    = soft_on ? `MODE_ON : `MODE_OFF;
   assign charger_on_o  = soft_on;
   assign sync_group_number_o = sync_group_number;

   // ***************************************
   // access sequencer
   // ***************************************
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= charger_regs_pkg::st_idle;
      end else begin
         case (state)
            charger_regs_pkg::st_idle: begin
               if (req_valid_i) begin
                  state <= charger_regs_pkg::st_answer;
               end
            end
            charger_regs_pkg::st_answer: begin
               state <= charger_regs_pkg::st_idle;
            end
            default: begin
               state <= charger_regs_pkg::st_idle;
            end
         endcase
      end
   end

   // ***************************************
   // read decode
   // ***************************************
   always_comb begin
      read_value  = 32'h0000_0000;
      id_known    = 1'b1;
      id_writable = 1'b0;
      case (req_id_i)
         `ID_PRODUCT_IDENTITY: begin
            read_value = {`IDENTITY_RESERVED, product_code_i, `IDENTITY_INSTANCE};
         end
         `ID_SYNC_GROUP: begin
            read_value  = {24'h00_0000, sync_group_number};
            id_writable = 1'b1;
         end
         `ID_FEATURE_FLAGS: begin
            read_value = feature_present_i & `FEATURE_DEFINED;
         end
         `ID_ON_OFF: begin
            read_value  = {24'h00_0000, mode_value};
            id_writable = 1'b1;
         end
         `ID_CHARGE_PHASE: begin
            read_value = {24'h00_0000, charge_phase};
         end
         `ID_REMOTE_MASK: begin
            read_value  = remote_enable_mask;
            id_writable = 1'b1;
         end
         `ID_CAUSE_NARROW: begin
            read_value = {24'h00_0000, shutdown_cause_narrow};
         end
         `ID_CAUSE_WIDE: begin
            read_value = shutdown_cause_wide;
         end
         default: begin
            id_known = 1'b0;
         end
      endcase
   end

   // ***************************************
   // answer
   // ***************************************
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rsp_data_o  <= 32'h0000_0000;
         rsp_error_o <= 1'b0;
      end else if (take) begin
         rsp_data_o  <= read_value;
         rsp_error_o <= ~id_known | (req_write_i & ~id_writable);
      end
   end

   // ***************************************
   // soft on/off switch
   // ***************************************
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         soft_on <= `SOFT_ON_RESET;
      end else if (mode_write_ok) begin
         if ((req_wdata_i[7:0] == `MODE_OFF) || (req_wdata_i[7:0] == `MODE_OFF_LEGACY)) begin
            soft_on <= 1'b0;
         end else if (req_wdata_i[7:0] == `MODE_ON) begin
            soft_on <= 1'b1;
         end
      end
   end

   // ***************************************
   // remote enable mask
   // ***************************************
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         remote_enable_mask <= `REMOTE_MASK_RESET;
      end else if (restart_i) begin
         remote_enable_mask <= `REMOTE_MASK_RESET;
      end else if (set_access && (req_id_i == `ID_REMOTE_MASK)) begin
         // reserved bits stored but steer nothing
         remote_enable_mask <= remote_enable_mask | req_wdata_i;
      end
   end

   // ***************************************
   // synchronised charging group
   // ***************************************
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync_group_number <= `SYNC_GROUP_RESET;
      end else if (set_access && (req_id_i == `ID_SYNC_GROUP)) begin
         sync_group_number <= req_wdata_i[7:0];
      end
   end

   // ***************************************
   // charge phase
   // ***************************************
   always_comb begin
      next_charge_phase = `PHASE_NO_INFO;
      if (manual_eq_i) begin
         next_charge_phase = `PHASE_MANUAL_EQ;
      end else if (auto_eq_i) begin
         next_charge_phase = `PHASE_AUTO_EQ;
      end else if (batt_protect_i) begin
         next_charge_phase = `PHASE_BULK;
      end else begin
         case (engine_phase_i)
            charger_regs_pkg::eng_idle:     next_charge_phase = `PHASE_NOT_CHARGING;
            charger_regs_pkg::eng_fault:    next_charge_phase = `PHASE_FAULT;
            charger_regs_pkg::eng_bulk:     next_charge_phase = `PHASE_BULK;
            charger_regs_pkg::eng_hold:     next_charge_phase = `PHASE_HOLD;
            charger_regs_pkg::eng_maintain: next_charge_phase = `PHASE_MAINTAIN;
            charger_regs_pkg::eng_storage:  next_charge_phase = `PHASE_STORAGE;
            charger_regs_pkg::eng_wake_up:  next_charge_phase = `PHASE_WAKE_UP;
            charger_regs_pkg::eng_update:   next_charge_phase = `PHASE_UPDATE;
            charger_regs_pkg::eng_external: next_charge_phase = `PHASE_EXTERNAL;
            default:                        next_charge_phase = `PHASE_NO_INFO;
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         charge_phase <= `PHASE_NO_INFO;
      end else begin
         charge_phase <= next_charge_phase;
      end
   end

   // ***************************************
   // shutdown causes
   // ***************************************
   always_comb begin
      next_cause                      = 32'h0000_0000;
      next_cause[`CAUSE_NO_INPUT]     = no_input_power_i;
      next_cause[`CAUSE_PHYS_SWITCH]  = physical_switch_off_i;
      next_cause[`CAUSE_SOFT_SWITCH]  = ~soft_on;
      next_cause[`CAUSE_REMOTE_INPUT] = remote_input_off_i;
      next_cause[`CAUSE_INTERNAL]     = internal_off_i;
      next_cause[`CAUSE_NO_CREDIT]    = credit_exhausted_i;
      next_cause[`CAUSE_BATT_MGMT]    = battery_management_system_off_i;
      next_cause[`CAUSE_BATT_COLD]    = battery_cold_i;
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         shutdown_cause_wide   <= 32'h0000_0000;
         shutdown_cause_narrow <= 8'h00;
      end else begin
         shutdown_cause_wide   <= next_cause & `CAUSE_DEFINED;
         shutdown_cause_narrow <= next_cause[7:0];
      end
   end

   // ***************************************
   // checks
   // ***************************************
   AST_IDENTITY_LAYOUT: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (take && !req_write_i && (req_id_i == `ID_PRODUCT_IDENTITY))
      |=> (rsp_valid_o && (rsp_data_o[7:0] == 8'h00) && (rsp_data_o[31:24] == 8'hff)
           && (rsp_data_o[23:8] == $past(product_code_i))))
      else $error("identity layout wrong");

   AST_FEATURE_GAPS: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (take && (req_id_i == `ID_FEATURE_FLAGS))
      |=> ((rsp_data_o[24:22] == 3'h0) && (rsp_data_o[31:28] == 4'h0)
           && (rsp_data_o[21:0] == $past(feature_present_i[21:0]))))
      else $error("feature flags wrong");

   AST_ANSWER_ONE_CYCLE: assert property (@(posedge clock_i) disable iff (!nrst_i)
      take |=> (rsp_valid_o && !req_ready_o) ##1 (!rsp_valid_o && req_ready_o))
      else $error("answer timing wrong");

   AST_MODE_OFF_WRITE: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (take && req_write_i && (req_id_i == `ID_ON_OFF) && remote_enable_mask[1]
       && ((req_wdata_i[7:0] == 8'h04) || (req_wdata_i[7:0] == 8'h00)))
      |=> !charger_on_o ##1 shutdown_cause_wide[2])
      else $error("off command not obeyed");

   AST_MODE_ON_WRITE: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (take && req_write_i && (req_id_i == `ID_ON_OFF) && remote_enable_mask[1]
       && (req_wdata_i[7:0] == 8'h01))
      |=> charger_on_o)
      else $error("on command not obeyed");

   AST_MODE_READBACK: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (take && !req_write_i && (req_id_i == `ID_ON_OFF))
      |=> (rsp_data_o == ($past(soft_on) ? 32'h0000_0001 : 32'h0000_0004)))
      else $error("mode read-back wrong");

   AST_MODE_IGNORED: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (take && req_write_i && (req_id_i == `ID_ON_OFF) && !remote_enable_mask[1])
      |=> $stable(charger_on_o))
      else $error("mode write taken without enable");

   AST_MASK_SET_ONLY: assert property (@(posedge clock_i) disable iff (!nrst_i)
      !restart_i |=> ((remote_enable_mask & $past(remote_enable_mask))
                      == $past(remote_enable_mask)))
      else $error("mask bit cleared without restart");

   AST_MASK_RESTART: assert property (@(posedge clock_i) disable iff (!nrst_i)
      restart_i |=> (remote_enable_mask == 32'h0000_0002))
      else $error("mask not back to default");

   AST_PHASE_PRIORITY: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (auto_eq_i && !manual_eq_i) |=> (charge_phase == 8'hf7))
      else $error("auto equalise phase wrong");

   AST_PHASE_MANUAL: assert property (@(posedge clock_i) disable iff (!nrst_i)
      manual_eq_i |=> (charge_phase == 8'h07))
      else $error("manual equalise phase wrong");

   AST_CAUSE_SHARED: assert property (@(posedge clock_i) disable iff (!nrst_i)
      1'b1 |=> (shutdown_cause_narrow[6:0] == shutdown_cause_wide[6:0])
               && (shutdown_cause_wide[9] == $past(battery_cold_i)))
      else $error("cause variants differ");

   AST_MASK_BITS_OR: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (set_access && (req_id_i == `ID_REMOTE_MASK) && !restart_i)
      |=> (remote_enable_mask == ($past(remote_enable_mask) | $past(req_wdata_i))))
      else $error("mask write not set-only");

   AST_MODE_OTHER_VALUE: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (take && req_write_i && (req_id_i == `ID_ON_OFF) && (req_wdata_i[7:0] != 8'h00)
       && (req_wdata_i[7:0] != 8'h01) && (req_wdata_i[7:0] != 8'h04))
      |=> $stable(charger_on_o))
      else $error("unknown mode value obeyed");

   AST_PHASE_PROTECT: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (batt_protect_i && !auto_eq_i && !manual_eq_i) |=> (charge_phase == 8'h03))
      else $error("protection start-up phase wrong");

   AST_PHASE_FAULT: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (!manual_eq_i && !auto_eq_i && !batt_protect_i
       && (engine_phase_i == charger_regs_pkg::eng_fault)) |=> (charge_phase == 8'h02))
      else $error("fault phase wrong");

   AST_PHASE_HOLD: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (!manual_eq_i && !auto_eq_i && !batt_protect_i
       && (engine_phase_i == charger_regs_pkg::eng_hold)) |=> (charge_phase == 8'h04))
      else $error("hold phase wrong");

   AST_PHASE_UPDATE: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (!manual_eq_i && !auto_eq_i && !batt_protect_i
       && (engine_phase_i == charger_regs_pkg::eng_update)) |=> (charge_phase == 8'hfa))
      else $error("update phase wrong");

   AST_PHASE_NO_INFO: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (!manual_eq_i && !auto_eq_i && !batt_protect_i
       && (engine_phase_i == charger_regs_pkg::eng_unknown)) |=> (charge_phase == 8'hff))
      else $error("no information phase wrong");

   AST_CAUSE_SOFT: assert property (@(posedge clock_i) disable iff (!nrst_i)
      1'b1 |=> (shutdown_cause_wide[2] == !$past(charger_on_o)))
      else $error("soft switch cause wrong");

endmodule

// file: tb/charger_host_model.sv
`timescale 1ns/10ps
`include "charger_regs_defines.svh"

module charger_host_model (
   // clock
   input  wire logic        clock_i,
   // requests to the device
   output logic             req_valid_o,
   output logic             req_write_o,
   output logic [15:0]      req_id_o,
   output logic [31:0]      req_wdata_o,
   // answers from the device
   input  wire logic        req_ready_i,
   input  wire logic        rsp_valid_i,
   input  wire logic [31:0] rsp_data_i,
   input  wire logic        rsp_error_i
);
   initial begin
      req_valid_o = 1'b0;
      req_write_o = 1'b0;
      req_id_o    = 16'h0000;
      req_wdata_o = 32'h0000_0000;
   end

   // one get or set; late flags an answer that misses its cycle
   task automatic xfer(input logic wr, input logic [15:0] id, input logic [31:0] wd,
                       output logic [31:0] data, output logic err, output logic late);
      int n;
      n = 0;
      @(posedge clock_i);
      #1;
      req_valid_o = 1'b1;
      req_write_o = wr;
      req_id_o    = id;
      req_wdata_o = wd;
      // ready looked at once settled, before the edge that takes it
      while (req_ready_i !== 1'b1 && n < 20) begin
         n++;
         @(posedge clock_i);
         #1;
      end
      @(posedge clock_i);
      #1;
      // answer taken while it stands, then valid dropped and write, id and data driven inverted
      late = (rsp_valid_i !== 1'b1) || (n == 20);
      data = rsp_data_i;
      err  = rsp_error_i;
      req_valid_o = 1'b0;
      req_write_o = ~wr;
      req_id_o    = ~id;
      req_wdata_o = ~wd;
   endtask

   // remote control enable bit written; each restart already sets it again
   task automatic enable_remote(output logic err, output logic late);
      logic [31:0] d;
      xfer(1'b1, `ID_REMOTE_MASK, 32'h0000_0002, d, err, late);
   endtask
endmodule

// file: tb/tb_charger_control_status_registers.sv
`timescale 1ns/10ps
`include "charger_regs_defines.svh"

module tb_charger_control_status_registers;
   // ***************************************
   // signals
   // ***************************************
   logic        clock_i = 1'b0;
   logic        nrst_i  = 1'b0;
   logic        req_valid, req_write, req_ready, rsp_valid, rsp_error;
   logic [15:0] req_id;
   logic [31:0] req_wdata, rsp_data;
   logic        restart = 1'b0;
   logic [15:0] product_code = 16'ha5c3;
   logic [31:0] feature = 32'h0000_0000;
   logic        manual_eq = 1'b0, auto_eq = 1'b0, batt_protect = 1'b0;
   logic [6:0]  causes = 7'h00;
   logic        charger_on;
   logic [7:0]  sync_group;
   int          error_cnt = 0;
   int          n_tests = 0;
   charger_regs_pkg::engine_phase_type engine_phase = charger_regs_pkg::eng_idle;

   always #5 clock_i = ~clock_i;

   charger_host_model host (.clock_i(clock_i), .req_valid_o(req_valid),
      .req_write_o(req_write), .req_id_o(req_id), .req_wdata_o(req_wdata),
      .req_ready_i(req_ready), .rsp_valid_i(rsp_valid), .rsp_data_i(rsp_data),
      .rsp_error_i(rsp_error));

   charger_control_status_registers dut (.clock_i(clock_i), .nrst_i(nrst_i),
      .req_valid_i(req_valid), .req_write_i(req_write), .req_id_i(req_id),
      .req_wdata_i(req_wdata), .req_ready_o(req_ready), .rsp_valid_o(rsp_valid),
      .rsp_data_o(rsp_data), .rsp_error_o(rsp_error), .restart_i(restart),
      .product_code_i(product_code), .feature_present_i(feature),
      .engine_phase_i(engine_phase), .manual_eq_i(manual_eq), .auto_eq_i(auto_eq),
      .batt_protect_i(batt_protect), .no_input_power_i(causes[0]),
      .physical_switch_off_i(causes[1]), .remote_input_off_i(causes[2]),
      .internal_off_i(causes[3]), .credit_exhausted_i(causes[4]),
      .battery_management_system_off_i(causes[5]), .battery_cold_i(causes[6]),
      .charger_on_o(charger_on), .sync_group_number_o(sync_group));

   // ***************************************
   // helpers
   // ***************************************
   task automatic tick;
      @(posedge clock_i);
      #1;
   endtask

   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_flag(input string what, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic get(input logic [15:0] id, input logic [31:0] exp, input logic ee);
      logic [31:0] d;
      logic        e, l;
      host.xfer(1'b0, id, 32'h0, d, e, l);
      chk_word($sformatf("read %h", id), exp, d);
      chk_flag($sformatf("read error %h", id), ee, e);
      chk_flag("answer timing", 1'b0, l);
   endtask

   task automatic put(input logic [15:0] id, input logic [31:0] wd, input logic ee);
      logic [31:0] d;
      logic        e, l;
      host.xfer(1'b1, id, wd, d, e, l);
      chk_flag($sformatf("write error %h", id), ee, e);
      chk_flag("answer timing", 1'b0, l);
   endtask

   task automatic pulse_restart;
      tick();
      restart = 1'b1;
      tick();
      restart = 1'b0;
   endtask

   // ***************************************
   // scenarios
   // ***************************************
   task automatic t_ident;
      get(`ID_PRODUCT_IDENTITY, 32'hffa5_c300, 1'b0);
      put(`ID_PRODUCT_IDENTITY, 32'h1234_5678, 1'b1);
      get(`ID_PRODUCT_IDENTITY, 32'hffa5_c300, 1'b0);
      put(`ID_SYNC_GROUP, 32'h0000_005a, 1'b0);
      chk_word("group output", 32'h5a, {24'h0, sync_group});
      get(`ID_SYNC_GROUP, 32'h0000_005a, 1'b0);
      get(16'h0101, 32'h0, 1'b1);
      get(16'h0203, 32'h0, 1'b1);
   endtask

   task automatic t_features;
      tick();
      feature = 32'hffff_ffff;
      get(`ID_FEATURE_FLAGS, 32'h0e3f_ffff, 1'b0);
      tick();
      feature = 32'h0124_8421;
      get(`ID_FEATURE_FLAGS, 32'h0024_8421, 1'b0);
      put(`ID_FEATURE_FLAGS, 32'h0, 1'b1);
   endtask

   task automatic t_mode;
      tick();
      engine_phase = charger_regs_pkg::eng_bulk;
      put(`ID_ON_OFF, 32'h4, 1'b0);
      chk_flag("charger on", 1'b0, charger_on);
      get(`ID_ON_OFF, 32'h4, 1'b0);
      get(`ID_CHARGE_PHASE, 32'h3, 1'b0);
      get(`ID_CAUSE_WIDE, 32'h4, 1'b0);
      put(`ID_ON_OFF, 32'h1, 1'b0);
      chk_flag("charger on", 1'b1, charger_on);
      get(`ID_ON_OFF, 32'h1, 1'b0);
      put(`ID_ON_OFF, 32'h0, 1'b0);
      chk_flag("charger on", 1'b0, charger_on);
      get(`ID_ON_OFF, 32'h4, 1'b0);
      put(`ID_ON_OFF, 32'h2, 1'b0);
      chk_flag("charger on", 1'b0, charger_on);
      put(`ID_ON_OFF, 32'h1, 1'b0);
   endtask

   task automatic t_mask;
      logic e, l;
      get(`ID_REMOTE_MASK, 32'h2, 1'b0);
      pulse_restart();
      get(`ID_REMOTE_MASK, 32'h2, 1'b0);
      put(`ID_ON_OFF, 32'h4, 1'b0);
      chk_flag("charger on", 1'b0, charger_on);
      put(`ID_REMOTE_MASK, 32'hffff_fffd, 1'b0);
      put(`ID_ON_OFF, 32'h1, 1'b0);
      chk_flag("charger on", 1'b1, charger_on);
      host.enable_remote(e, l);
      chk_flag("mask write error", 1'b0, e);
      put(`ID_REMOTE_MASK, 32'h0, 1'b0);
      get(`ID_REMOTE_MASK, 32'hffff_ffff, 1'b0);
      put(`ID_ON_OFF, 32'h4, 1'b0);
      chk_flag("charger on", 1'b0, charger_on);
      put(`ID_ON_OFF, 32'h1, 1'b0);
      pulse_restart();
      get(`ID_REMOTE_MASK, 32'h2, 1'b0);
      chk_flag("charger on", 1'b1, charger_on);
   endtask

   task automatic t_phase;
      logic [7:0] map [10] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05,
                               8'h06, 8'hf5, 8'hfa, 8'hfc, 8'hff};
      for (int i = 0; i < 10; i++) begin
         tick();
         engine_phase = charger_regs_pkg::engine_phase_type'(i[3:0]);
         get(`ID_CHARGE_PHASE, {24'h0, map[i]}, 1'b0);
      end
      tick();
      batt_protect = 1'b1;
      get(`ID_CHARGE_PHASE, 32'h03, 1'b0);
      tick();
      auto_eq = 1'b1;
      get(`ID_CHARGE_PHASE, 32'hf7, 1'b0);
      tick();
      manual_eq = 1'b1;
      get(`ID_CHARGE_PHASE, 32'h07, 1'b0);
      tick();
      {manual_eq, auto_eq, batt_protect} = 3'b000;
   endtask

   task automatic t_cause;
      int pos [7] = '{0, 1, 3, 4, 5, 6, 9};
      for (int i = 0; i < 7; i++) begin
         tick();
         causes = 7'h01 << i;
         get(`ID_CAUSE_WIDE, 32'h1 << pos[i], 1'b0);
         get(`ID_CAUSE_NARROW, (32'h1 << pos[i]) & 32'hff, 1'b0);
      end
      tick();
      causes = 7'h7f;
      get(`ID_CAUSE_WIDE, 32'h0000_027b, 1'b0);
      get(`ID_CAUSE_NARROW, 32'h0000_007b, 1'b0);
   endtask

   task automatic t_rereset;
      put(`ID_ON_OFF, 32'h4, 1'b0);
      tick();
      nrst_i = 1'b0;
      tick();
      tick();
      nrst_i = 1'b1;
      chk_flag("charger on", 1'b1, charger_on);
      chk_word("group output", 32'h0, {24'h0, sync_group});
      get(`ID_REMOTE_MASK, 32'h2, 1'b0);
   endtask

   // ***************************************
   // run control
   // ***************************************
   task automatic results;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge clock_i);
      #1;
      nrst_i = 1'b1;
      t_ident();
      t_features();
      t_mode();
      t_mask();
      t_phase();
      t_cause();
      t_rereset();
      results();
   end

   initial begin
      #100000;
      error_cnt++;
      results();
   end
endmodule
